// >>> design/iec_top.sv
`timescale 1ns/10ps
`default_nettype none
module iec_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register access
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // port 2 pins
    input wire logic shared_port_pin_in,
    output logic shared_port_pin_out,
    output logic shared_port_pin_oe,
    output logic [7:0] port2_out_en,
    // event
    output logic match_interrupt
);
    logic [7:0] port2_direction_r;
    logic [7:0] timer_mode_control_r;
    logic [7:0] compare_value_r;
    logic [7:0] counter_value_r;
    logic [7:0] counter_value_nxt;
    logic [7:0] prescale_r;
    logic [7:0] reg_rdata_r;
    logic match_interrupt_r;
    logic counter_run_bit;
    iec_pkg::iec_sel_t clk_sel;
    logic pin_rise;
    logic pin_fall;
    logic tick;
    logic hit;

    // ------------------------------------------------------------
    // pin edge detection
    // ------------------------------------------------------------
    iec_edge_sync u_edge (
        .clock(clock),
        .rst(rst),
        .pin_in(shared_port_pin_in),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            port2_direction_r <= iec_pkg::PORT2_DIR_RESET;
        end else if (reg_wr && reg_addr == iec_pkg::ADDR_PORT2_DIR) begin
            port2_direction_r <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            timer_mode_control_r <= iec_pkg::MODE_CTRL_RESET;
        end else if (reg_wr && reg_addr == iec_pkg::ADDR_MODE_CTRL) begin
            // bits 5..3 are fixed at zero
            timer_mode_control_r <= reg_wdata & iec_pkg::MODE_CTRL_MASK;
        end
    end

    // a running counter sees a new compare at once, so a match may fire
    always_ff @(posedge clock) begin
        if (rst) begin
            compare_value_r <= iec_pkg::COMPARE_RESET;
        end else if (reg_wr && reg_addr == iec_pkg::ADDR_COMPARE) begin
            compare_value_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // register reads, one cycle latency, unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                iec_pkg::ADDR_PORT2_DIR: reg_rdata_r <= port2_direction_r;
                iec_pkg::ADDR_MODE_CTRL: reg_rdata_r <= timer_mode_control_r;
                iec_pkg::ADDR_COMPARE: reg_rdata_r <= compare_value_r;
                iec_pkg::ADDR_COUNTER: reg_rdata_r <= counter_value_r;
                default: reg_rdata_r <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_r;

    // ------------------------------------------------------------
    // pin direction
    // ------------------------------------------------------------
    assign port2_out_en = ~port2_direction_r;
    assign shared_port_pin_oe =
        ~port2_direction_r[iec_pkg::SHARED_PIN_BIT];
    // waveform output left out; the pin drives its cleared latch level
    assign shared_port_pin_out = 1'b0;

    // ------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------
    assign counter_run_bit = timer_mode_control_r[iec_pkg::RUN_BIT];
    assign clk_sel = iec_pkg::iec_sel_t'(timer_mode_control_r[
        iec_pkg::SEL_HI_BIT:iec_pkg::SEL_LO_BIT]);

    // prescaler restarts with the run bit so the first period is exact
    always_ff @(posedge clock) begin
        if (rst || !counter_run_bit) begin
            prescale_r <= 8'h00;
        end else begin
            prescale_r <= prescale_r + 8'h01;
        end
    end

    always_comb begin
        case (clk_sel)
            iec_pkg::IEC_SEL_SYS: tick = 1'b1;
            iec_pkg::IEC_SEL_DIV:
                tick = (prescale_r == iec_pkg::PRESCALE_LAST);
            iec_pkg::IEC_SEL_RISE: tick = pin_rise;
            iec_pkg::IEC_SEL_FALL: tick = pin_fall;
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // counter and match
    // ------------------------------------------------------------
    assign hit = counter_run_bit && tick &&
        (counter_value_r == compare_value_r);

    always_comb begin
        if (!counter_run_bit) begin
            counter_value_nxt = 8'h00;
        end else if (hit) begin
            counter_value_nxt = 8'h00;
        end else if (tick) begin
            counter_value_nxt = counter_value_r + 8'h01;
        end else begin
            counter_value_nxt = counter_value_r;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            counter_value_r <= iec_pkg::COUNTER_RESET;
        end else begin
            counter_value_r <= counter_value_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            match_interrupt_r <= 1'b0;
        end else begin
            match_interrupt_r <= hit;
        end
    end

    assign match_interrupt = match_interrupt_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence match_seq;
        counter_run_bit && tick && counter_value_r == compare_value_r;
    endsequence

    sequence cleared_seq;
        counter_value_r == 8'h00 && match_interrupt;
    endsequence

    dir_reset_value_a: assert property (@(posedge clock)
        rst |=> port2_direction_r == 8'hFF)
        else $error("direction register not all ones after reset");

    pin_buffer_a: assert property (@(posedge clock)
        disable iff (rst)
        reg_wr && reg_addr == iec_pkg::ADDR_PORT2_DIR
        |=> shared_port_pin_oe == !$past(reg_wdata[7]))
        else $error("shared pin buffer does not follow direction bit");

    match_clear_a: assert property (@(posedge clock)
        disable iff (rst)
        match_seq |=> cleared_seq)
        else $error("counter not cleared with interrupt on match");

    irq_cause_a: assert property (@(posedge clock)
        disable iff (rst)
        match_interrupt |-> counter_value_r == 8'h00 &&
        $past(counter_value_r) == $past(compare_value_r) &&
        $past(counter_run_bit))
        else $error("interrupt without a compare match");

    stop_hold_a: assert property (@(posedge clock)
        disable iff (rst)
        !counter_run_bit |=> counter_value_r == 8'h00 && !match_interrupt)
        else $error("stopped counter not held at zero");

    fast_count_a: assert property (@(posedge clock)
        disable iff (rst)
        counter_run_bit && clk_sel == iec_pkg::IEC_SEL_SYS &&
        counter_value_r != compare_value_r
        |=> counter_value_r == $past(counter_value_r) + 8'h01)
        else $error("system clock count did not step");

    slow_count_a: assert property (@(posedge clock)
        disable iff (rst)
        counter_run_bit && clk_sel == iec_pkg::IEC_SEL_DIV &&
        prescale_r != 8'hFF |=> $stable(counter_value_r))
        else $error("divided clock counted between prescaler ends");

    edge_count_a: assert property (@(posedge clock)
        disable iff (rst)
        counter_run_bit && clk_sel == iec_pkg::IEC_SEL_RISE && !pin_rise
        |=> $stable(counter_value_r))
        else $error("rising edge mode counted without an edge");

    fall_count_a: assert property (@(posedge clock)
        disable iff (rst)
        counter_run_bit && clk_sel == iec_pkg::IEC_SEL_FALL && pin_fall &&
        counter_value_r != compare_value_r
        |=> counter_value_r == $past(counter_value_r) + 8'h01)
        else $error("falling edge not counted");

    zero_period_a: assert property (@(posedge clock)
        disable iff (rst)
        counter_run_bit && clk_sel == iec_pkg::IEC_SEL_SYS &&
        compare_value_r == 8'h00 && $stable(compare_value_r) ##1
        counter_run_bit && $stable(timer_mode_control_r)
        |=> match_interrupt)
        else $error("compare zero does not match every count");
endmodule
`default_nettype wire

// >>> inc/iec_pkg.sv
// Summary of operation
// - reset loads port direction register with all ones, every pin input.
// - direction bit zero turns pin output buffer on, one turns it off.
// - on compare match the counter clears to zero and keeps counting.
// - match interrupt pulses in the same cycle the counter clears.
// - compare value 00 to FF gives a period of value plus one counts.
// - code 00 counts system clock, 01 counts clock divided by 256.
// - event mode counts once per valid edge, polarity from bit 1.
// - event counts come from the shared port pin.
// - run bit zero holds counter cleared; one lets it count.
// - code 10 counts rising edges, code 11 falling; no timer output then.
`default_nettype none
package iec_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT2_DIR = 16'hFF22;
    localparam logic [15:0] ADDR_MODE_CTRL = 16'hFF53;
    localparam logic [15:0] ADDR_COMPARE = 16'hFF4C;
    localparam logic [15:0] ADDR_COUNTER = 16'hFF4D;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PORT2_DIR_RESET = 8'hFF;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    // ------------------------------------------------------------
    // mode control fields
    // ------------------------------------------------------------
    localparam int RUN_BIT = 7;
    localparam int PWM_BIT = 6;
    localparam int SEL_HI_BIT = 2;
    localparam int SEL_LO_BIT = 1;
    localparam int OUT_EN_BIT = 0;
    localparam logic [7:0] MODE_CTRL_MASK = 8'hC7;
    localparam int SHARED_PIN_BIT = 7;
    // ------------------------------------------------------------
    // count clock selection and prescaler
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IEC_SEL_SYS = 2'b00,
        IEC_SEL_DIV = 2'b01,
        IEC_SEL_RISE = 2'b10,
        IEC_SEL_FALL = 2'b11
    } iec_sel_t;
    localparam int PRESCALE_LOG2 = 8;
    localparam logic [7:0] PRESCALE_LAST = 8'hFF;
endpackage
`default_nettype wire

// >>> design/iec_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module iec_edge_sync (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // asynchronous pin
    input wire logic pin_in,
    // one-cycle edge pulses
    output logic rise,
    output logic fall
);
    logic sync1_r;
    logic sync2_r;
    logic last_r;

    // ------------------------------------------------------------
    // two-flop synchroniser, then a history flop for edges
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            last_r <= sync2_r;
        end
    end

    // edges only from settled flops; sync1 stays private
    assign rise = sync2_r & ~last_r;
    assign fall = ~sync2_r & last_r;
endmodule
`default_nettype wire

// >>> dv/iec_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// external pulse source on the shared pin
// ------------------------------------------------------------
module iec_pulse_src (
    // clock
    input wire logic clock,
    // pin level
    output logic pin
);
    initial pin = 1'h0;
    // idle level chosen while the counter is stopped
    task automatic set_level(input logic v);
        @(posedge clock);
        pin <= v;
    endtask
    // 4 cycles a phase, so the synchroniser sees every edge
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clock);
            pin <= ~pin;
            repeat (4) @(posedge clock);
            pin <= ~pin;
        end
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [15:0] A_DIR = iec_pkg::ADDR_PORT2_DIR;
    localparam logic [15:0] A_MODE = iec_pkg::ADDR_MODE_CTRL;
    localparam logic [15:0] A_CMP = iec_pkg::ADDR_COMPARE;
    localparam logic [15:0] A_CNT = iec_pkg::ADDR_COUNTER;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic pin;
    logic pin_out;
    logic pin_oe;
    logic [7:0] out_en;
    logic irq;
    int bad_count = 0;
    int checked = 0;
    int irq_cnt = 0;
    int gap;
    int n0;
    int cfg [5][3] = '{'{0, 0, 1}, '{0, 2, 3}, '{0, 255, 256},
                       '{1, 0, 256}, '{1, 1, 512}};
    always #50 clock = ~clock;
    always @(posedge clock) begin
        if (irq === 1'h1) irq_cnt <= irq_cnt + 1;
    end
    iec_top DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .shared_port_pin_in(pin),
        .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe),
        .port2_out_en(out_en), .match_interrupt(irq));
    iec_pulse_src src (.clock(clock), .pin(pin));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("mismatches %0d checks %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e,
                      input string what);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        @(negedge clock);
        chk(what, {8'h00, e}, {8'h00, reg_rdata});
    endtask
    // stop, select clock, compare, then run; clock and run apart
    task automatic start(input logic [1:0] sel, input logic [7:0] n);
        wr(A_MODE, 8'h00);
        wr(A_MODE, {5'h00, sel, 1'h0});
        wr(A_CMP, n);
        wr(A_MODE, {5'h10, sel, 1'h0});
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (irq !== 1'h1 && n < 3000);
        if (n >= 3000) begin
            bad_count++;
            $display("Error match pulse expected 1 seen 0");
            finish_test();
        end
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'h0;
        rd(A_DIR, 8'hFF, "direction reset");
        rd(A_MODE, 8'h00, "mode reset");
        rd(A_CNT, 8'h00, "counter reset");
        chk("buffer enables", 16'h0000, {8'h00, out_en});
        chk("pin drive", 16'h0000, {15'h0000, pin_oe});
        wr(A_DIR, 8'h5A);
        @(negedge clock);
        chk("buffer enables", 16'h00A5, {8'h00, out_en});
        chk("pin drive", 16'h0001, {15'h0000, pin_oe});
        chk("pin level", 16'h0000, {15'h0000, pin_out});
        rd(A_DIR, 8'h5A, "direction readback");
        wr(A_MODE, 8'h7F);
        rd(A_MODE, 8'h47, "mode fields");
        rd(16'hFF00, 8'h00, "unmapped read");
        for (int i = 0; i < 5; i++) begin
            start(2'(cfg[i][0]), 8'(cfg[i][1]));
            wait_irq(gap);
            wait_irq(gap);
            chk("match period", 16'(cfg[i][2]), 16'(gap));
        end
        start(2'h1, 8'h05);
        wait_irq(gap);
        rd(A_CNT, 8'h00, "count at match");
        wr(A_MODE, 8'h00);
        n0 = irq_cnt;
        repeat (1600) @(posedge clock);
        chk("stopped matches", 16'h0000, 16'(irq_cnt - n0));
        rd(A_CNT, 8'h00, "stopped count");
        wr(A_DIR, 8'hFF);
        src.set_level(1'h0);
        start(2'h2, 8'h02);
        n0 = irq_cnt;
        src.pulses(6);
        repeat (8) @(posedge clock);
        chk("rising matches", 16'h0002, 16'(irq_cnt - n0));
        rd(A_CNT, 8'h00, "rising count");
        wr(A_MODE, 8'h00);
        src.set_level(1'h1);
        start(2'h3, 8'h01);
        n0 = irq_cnt;
        src.pulses(3);
        repeat (8) @(posedge clock);
        chk("falling matches", 16'h0001, 16'(irq_cnt - n0));
        rd(A_CNT, 8'h01, "falling count");
        finish_test();
    end
endmodule
`default_nettype wire
